/* core/ssrp_device.sv */
// sensor side of the serial register port: 4-wire and two-wire slave
// assumes link pins asynchronous to mclk, sck well below mclk/6
`timescale 1ns/1ps
module ssrp_device
  import ssrp_pkg::*;
#(
  parameter int IMM_BANK = 0,
  parameter logic [7:0] IMM_LO = 8'h00,
  parameter logic [7:0] IMM_HI = 8'h0F
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // link
  ssrp_if.device lnk,
  // user side
  input wire logic frame_point,
  input wire logic [2:0] rd_bank,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic link_spi,
  output logic link_i2c
);
  typedef logic [NBANK-1:0][BANK_BYTES-1:0][7:0] ssrp_mem_t;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic spi_f;
    logic i2c_f;
    logic [2:0] bcnt;
    logic [1:0] field;
    logic [7:0] sh;
    logic [2:0] bank;
    logic wr;
    logic ok;
    logic [7:0] addr;
    logic [7:0] osh;
    logic serial_data_out;
    logic sdo_oe;
    ssrp_i2c_e ist;
    logic [2:0] icnt;
    logic [7:0] ish;
    logic [1:0] ikind;
    logic ird;
    logic iack;
    logic [15:0] idx;
    logic sda_oe;
    ssrp_mem_t mem;
    ssrp_mem_t act;
    logic [7:0] rd_data;
  } ssrp_dev_s;

  ssrp_dev_s r;
  ssrp_dev_s n;
  logic sel_n, sck, sdi, psel, psck, psdi;
  logic rise, fall, sel_fall, start, stop;
  logic iok;
  logic [2:0] ib;
  logic [7:0] ird_byte;

  // ----------------------------------------------------------------
  // synchronised pins and their edges
  // ----------------------------------------------------------------
  assign {sel_n, sck, sdi} = r.s2;
  assign {psel, psck, psdi} = r.s3;
  assign rise = sck & ~psck;
  assign fall = ~sck & psck;
  assign sel_fall = ~sel_n & psel;
  assign start = sel_n & sck & psck & psdi & ~sdi;
  assign stop = sel_n & sck & psck & ~psdi & sdi;
  assign iok = r.idx[15:8] >= I2C_BANK_BASE &&
    r.idx[15:8] < I2C_BANK_BASE + 8'(NBANK);
  assign ib = 3'(r.idx[15:8] - I2C_BANK_BASE);
  assign ird_byte = iok ? r.mem[ib][r.idx[7:0]] : 8'h00;

  function automatic logic imm(input logic [2:0] b, input logic [7:0] a);
    imm = b == 3'(IMM_BANK) && a >= IMM_LO && a <= IMM_HI;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic we;
    logic [2:0] wb;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] bv;
    logic [7:0] lo;
    we = 1'b0;
    wb = 3'h0;
    wa = 8'h00;
    wd = 8'h00;
    bv = 8'h00;
    lo = 8'h00;
    n = r;
    n.s1 = {lnk.sel_n, lnk.sck, lnk.sdi_line};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // link type chosen once
    if (!r.spi_f && !r.i2c_f)
    begin
      if (sel_fall)
        n.spi_f = 1'b1;
      else if (start)
        n.i2c_f = 1'b1;
    end
    // 4-wire slave
    if (r.spi_f)
    begin
      n.sdo_oe = ~sel_n;
      if (sel_n)
      begin
        n.bcnt = 3'h0;
        n.field = FLD_CODE;
        n.ok = 1'b0;
      end
      else if (rise)
      begin
        bv = {sdi, r.sh[7:1]};
        n.sh = bv;
        n.bcnt = r.bcnt + 3'h1;
        if (r.bcnt == BIT_LAST)
        begin
          if (r.field == FLD_CODE)
          begin
            lo = {1'b0, bv[6:0]};
            n.ok = lo >= CODE_WR_LO && lo <= CODE_WR_HI;
            n.wr = ~bv[CODE_RD_BIT];
            n.bank = 3'(lo - CODE_WR_LO);
            n.field = FLD_ADDR;
          end
          else if (r.field == FLD_ADDR && r.ok)
          begin
            n.addr = bv;
            n.osh = r.mem[r.bank][bv];
            n.field = FLD_DATA;
          end
          else if (r.field == FLD_DATA && r.ok)
          begin
            if (r.wr)
            begin
              we = 1'b1;
              wb = r.bank;
              wa = r.addr;
              wd = bv;
            end
            n.addr = r.addr + 8'h01;
            n.osh = r.mem[r.bank][n.addr];
          end
        end
      end
      else if (fall && r.bcnt != 3'h0)
        n.osh = {1'b0, r.osh[7:1]};
      n.serial_data_out = n.osh[0];
    end
    // two-wire slave
    if (r.i2c_f || (!r.spi_f && start))
    begin
      if (start)
      begin
        n.ist = I_RECV;
        n.icnt = 3'h0;
        n.ikind = KIND_DEV;
        n.sda_oe = 1'b0;
      end
      else if (stop)
      begin
        n.ist = I_IDLE;
        n.sda_oe = 1'b0;
      end
      else if (rise)
      begin
        unique case (r.ist)
          I_RECV:
          begin
            bv = {r.ish[6:0], sdi};
            n.ish = bv;
            n.icnt = r.icnt + 3'h1;
            if (r.icnt == BIT_LAST)
            begin
              n.ist = I_ACK;
              n.iack = 1'b0;
              if (r.ikind == KIND_DEV)
              begin
                if (bv[7:1] != I2C_DEV_ADDR)
                  n.ist = I_IDLE;
                n.ird = bv[0] == I2C_DIR_RD;
                n.ikind = KIND_AHI;
              end
              else if (r.ikind == KIND_AHI)
              begin
                n.idx[15:8] = bv;
                n.ikind = KIND_ALO;
              end
              else if (r.ikind == KIND_ALO)
              begin
                n.idx[7:0] = bv;
                n.ikind = KIND_DATA;
              end
              else
              begin
                we = iok;
                wb = ib;
                wa = r.idx[7:0];
                wd = bv;
                n.idx = r.idx + 16'h0001;
              end
            end
          end
          I_MACK:
          begin
            n.ist = sdi ? I_IDLE : I_LOAD;
            n.idx = r.idx + 16'h0001;
          end
          I_SEND: n.icnt = r.icnt + 3'h1;
          default: ;
        endcase
      end
      else if (fall)
      begin
        if (r.ist == I_ACK && !r.iack)
        begin
          n.sda_oe = 1'b1;
          n.iack = 1'b1;
        end
        else if (r.ist == I_ACK && !r.ird)
        begin
          n.sda_oe = 1'b0;
          n.ist = I_RECV;
          n.icnt = 3'h0;
        end
        else if (r.ist == I_ACK || r.ist == I_LOAD)
        begin
          n.ish = ird_byte;
          n.sda_oe = ~ird_byte[7];
          n.ist = I_SEND;
          n.icnt = 3'h0;
        end
        else if (r.ist == I_SEND && r.icnt == 3'h0)
        begin
          n.sda_oe = 1'b0;
          n.ist = I_MACK;
        end
        else if (r.ist == I_SEND)
        begin
          n.ish = {r.ish[6:0], 1'b0};
          n.sda_oe = ~r.ish[6];
        end
      end
    end
    // store and applied copy
    if (frame_point)
      n.act = r.mem;
    if (we)
    begin
      n.mem[wb][wa] = wd;
      if (imm(wb, wa))
        n.act[wb][wa] = wd;
    end
    n.rd_data = rd_bank < 3'(NBANK) ? r.act[rd_bank][rd_addr] : 8'h00;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      r <= '0;
    else
      r <= n;
  end

  assign lnk.serial_data_out = r.serial_data_out;
  assign lnk.sdo_oe = r.sdo_oe;
  assign lnk.dev_sda_oe = r.sda_oe;
  assign rd_data = r.rd_data;
  assign link_spi = r.spi_f;
  assign link_i2c = r.i2c_f;
endmodule // ssrp_device

/* core/ssrp_pkg.sv */
// constants and types shared by both ends of the serial register port
// assumes a single 100 MHz mclk on both ends
package ssrp_pkg;
  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  localparam int NBANK = 5;
  localparam int BANK_BYTES = 256;
  localparam logic [7:0] CODE_WR_LO = 8'h02;
  localparam logic [7:0] CODE_WR_HI = 8'h06;
  localparam int CODE_RD_BIT = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] FLD_CODE = 2'h0;
  localparam logic [1:0] FLD_ADDR = 2'h1;
  localparam logic [1:0] FLD_DATA = 2'h2;
  // ----------------------------------------------------------------
  // two-wire link
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_DEV_ADDR = 7'h1A;
  localparam logic I2C_DIR_RD = 1'h1;
  localparam logic [7:0] I2C_BANK_BASE = 8'h30;
  localparam logic [1:0] KIND_DEV = 2'h0;
  localparam logic [1:0] KIND_AHI = 2'h1;
  localparam logic [1:0] KIND_ALO = 2'h2;
  localparam logic [1:0] KIND_DATA = 2'h3;
  typedef enum logic [2:0] {I_IDLE, I_RECV, I_ACK, I_LOAD, I_SEND, I_MACK}
    ssrp_i2c_e;
  // ----------------------------------------------------------------
  // controller timing and registers
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 80;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam int MAX_DATA = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TXD0 = 8'h08;
  localparam logic [7:0] OFS_TXD1 = 8'h0C;
  localparam logic [7:0] OFS_RXD0 = 8'h10;
  localparam logic [7:0] OFS_RXD1 = 8'h14;
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_CNT_LSB = 16;
  localparam int CTRL_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_LOW, H_HIGH, H_TAIL}
    ssrp_host_e;
endpackage

/* core/ssrp_if.sv */
// shared pins between the controller and the sensor register port
// assumes pull-ups on the data lines; levels resolved from the enables
`timescale 1ns/1ps
interface ssrp_if;
  logic sel_n;
  logic sck;
  logic host_sdi;
  logic host_sdi_oe;
  logic dev_sda_oe;
  logic serial_data_out;
  logic sdo_oe;
  logic sdi_line;
  logic sdo_line;
  // open-drain data line, device only pulls low
  assign sdi_line = ~((host_sdi_oe & ~host_sdi) | dev_sda_oe);
  assign sdo_line = sdo_oe ? serial_data_out : 1'b1;
  modport host(output sel_n, output sck, output host_sdi,
    output host_sdi_oe, input sdo_line, input sdi_line);
  modport device(input sel_n, input sck, input sdi_line,
    output dev_sda_oe, output serial_data_out, output sdo_oe);
endinterface

/* core/ssrp_host.sv */
// controller side: 4-wire master driven by an AXI4-Lite register slave
// assumes window_ok comes from logic on mclk
`timescale 1ns/1ps
module ssrp_host
  import ssrp_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // link
  ssrp_if.host lnk,
  // transfer window from sensor timing
  input wire logic window_ok,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic [1:0] sdo_s;
    logic [7:0] tick;
    ssrp_host_e hst;
    logic [6:0] bitpos;
    logic [7:0] code;
    logic [7:0] addr;
    logic [3:0] cnt;
    logic [8*MAX_DATA-1:0] tx;
    logic [8*MAX_DATA-1:0] rx;
    logic busy;
    logic done;
    logic sel_n;
    logic sck;
    logic sdi;
    logic sdi_oe;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssrp_host_s;

  ssrp_host_s r;
  ssrp_host_s n;

  // bit of the outgoing frame at a position
  function automatic logic txbit(input ssrp_host_s s, input logic [6:0] p);
    logic [7:0] b;
    b = p[6:3] == 4'h0 ? s.code :
      p[6:3] == 4'h1 ? s.addr : s.tx[8*(p[6:3]-4'h2) +: 8];
    txbit = b[p[2:0]];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
  endfunction

  always_comb
  begin
    logic tk;
    logic [6:0] last;
    tk = r.tick == 8'(HALF - 1);
    last = 7'({r.cnt, 3'h0}) + 7'h0F;
    n = r;
    n.sdo_s = {r.sdo_s[0], lnk.sdo_line};
    n.sdi_oe = 1'b1;
    n.tick = tk ? 8'h00 : r.tick + 8'h01;
    // ----------------------------------------------------------------
    // link sequencer
    // ----------------------------------------------------------------
    unique case (r.hst)
      H_IDLE: n.sel_n = 1'b1;
      H_WAIT:
        if (window_ok)
        begin
          n.sel_n = 1'b0;
          n.bitpos = 7'h00;
          n.sdi = txbit(r, 7'h00);
          n.tick = 8'h00;
          n.hst = H_LOW;
        end
      H_LOW:
        if (tk)
        begin
          n.sck = 1'b1;
          n.hst = H_HIGH;
        end
      H_HIGH:
        if (tk)
        begin
          n.sck = 1'b0;
          if (r.bitpos[6:3] >= 4'h2)
            n.rx[8*(r.bitpos[6:3]-4'h2) + r.bitpos[2:0]] = r.sdo_s[1];
          if (r.bitpos == last)
            n.hst = H_TAIL;
          else
          begin
            n.bitpos = r.bitpos + 7'h01;
            n.sdi = txbit(r, n.bitpos);
            n.hst = H_LOW;
          end
        end
      H_TAIL:
        if (tk)
        begin
          n.sel_n = 1'b1;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.hst = H_IDLE;
        end
    endcase
    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    if (r.awready && awvalid)
    begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (r.wready && wvalid)
    begin
      n.w_got = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (r.bvalid && bready)
      n.bvalid = 1'b0;
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = AXI_OKAY;
      unique case (r.aw_addr)
        OFS_CTRL:
          if (!r.busy && r.w_data[CTRL_GO_BIT] && &r.w_strb)
          begin
            n.code = r.w_data[CTRL_CODE_LSB +: 8];
            n.addr = r.w_data[CTRL_ADDR_LSB +: 8];
            n.cnt = r.w_data[CTRL_CNT_LSB +: 4] > 4'(MAX_DATA) ?
              4'(MAX_DATA) : r.w_data[CTRL_CNT_LSB +: 4];
            n.busy = 1'b1;
            n.done = 1'b0;
            n.hst = H_WAIT;
          end
        OFS_TXD0: n.tx[31:0] = merge(r.tx[31:0], r.w_data, r.w_strb);
        OFS_TXD1: n.tx[63:32] = merge(r.tx[63:32], r.w_data, r.w_strb);
        OFS_STAT, OFS_RXD0, OFS_RXD1: ;
        default: n.bresp = AXI_SLVERR;
      endcase
    end
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready = ~n.w_got & ~n.bvalid;
    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    if (r.arready && arvalid)
    begin
      n.rvalid = 1'b1;
      n.rresp = AXI_OKAY;
      unique case (araddr)
        OFS_CTRL: n.rdata = {12'h000, r.cnt, r.addr, r.code};
        OFS_STAT: n.rdata = {30'h00000000, r.done, r.busy};
        OFS_TXD0: n.rdata = r.tx[31:0];
        OFS_TXD1: n.rdata = r.tx[63:32];
        OFS_RXD0: n.rdata = r.rx[31:0];
        OFS_RXD1: n.rdata = r.rx[63:32];
        default:
        begin
          n.rdata = 32'h00000000;
          n.rresp = AXI_SLVERR;
        end
      endcase
    end
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
      r.sel_n <= 1'b1;
    end
    else
      r <= n;
  end

  assign lnk.sel_n = r.sel_n;
  assign lnk.sck = r.sck;
  assign lnk.host_sdi = r.sdi;
  assign lnk.host_sdi_oe = r.sdi_oe;
  assign awready = r.awready;
  assign wready = r.wready;
  assign bresp = r.bresp;
  assign bvalid = r.bvalid;
  assign arready = r.arready;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign rvalid = r.rvalid;
endmodule // ssrp_host

/* bench/ssrp_monitor.sv */
// link checker for the serial register port, fed the shared pin signals
// assumes host sck half period of 4 mclk and one mclk domain
`timescale 1ns/1ps
module ssrp_monitor
  import ssrp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // link
  input wire logic sel_n,
  input wire logic sck,
  input wire logic host_sdi,
  input wire logic sdo_oe,
  input wire logic dev_sda_oe
);
  // ----------------------------------------------------------------
  // sck rise count within a frame
  // ----------------------------------------------------------------
  logic sck_q_r;
  logic [2:0] bits_r;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sck_q_r <= 1'b0;
      bits_r <= 3'h0;
    end
    else
    begin
      sck_q_r <= sck;
      if (sel_n)
        bits_r <= 3'h0;
      else if (sck && !sck_q_r)
        bits_r <= bits_r + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  idle_no_drive_a: assert property (sel_n [*6] |-> !sdo_oe)
    else $error("sdo driven while link idle");
  drive_open_a: assert property ($fell(sel_n) |-> ##[1:6] sdo_oe)
    else $error("sdo not driven after frame open");
  drive_close_a: assert property ($rose(sel_n) |-> ##[1:6] !sdo_oe)
    else $error("sdo not released after frame close");
  no_pull_a: assert property (!sel_n |-> !dev_sda_oe)
    else $error("data line pulled during 4-wire frame");
  idle_sck_a: assert property (sel_n |-> !sck)
    else $error("sck moves outside frame");
  sdi_hold_a: assert property (sck |-> $stable(host_sdi))
    else $error("sdi changed while sck high");
  sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase wrong length");
  lead_in_a: assert property ($fell(sel_n) |-> !sck [*4] ##1 sck)
    else $error("first sck rise not half period after open");
  whole_bytes_a: assert property ($rose(sel_n) |-> bits_r == 3'h0)
    else $error("frame not whole bytes");
endmodule // ssrp_monitor

/* bench/tb_top.sv */
// self-checking bench: host and device joined by the link interface
// assumes both design ends on one 100 MHz mclk
`timescale 1ns/1ps
module tb_top
  import ssrp_pkg::*;
;
  logic mclk, reset, window_ok, frame_point;
  logic [2:0] rd_bank;
  logic [7:0] rd_addr, rd_data, awaddr, araddr;
  logic link_spi, link_i2c;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sck_q;
  logic [31:0] wdata, rdata, rd_word, rx0, tx_bits, rx_bits;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  int bad_count, checks_done, cycles;
  ssrp_if lnk();
  ssrp_host u_ssrp_host(.mclk, .reset, .lnk(lnk), .window_ok, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  ssrp_device u_ssrp_device(.mclk, .reset, .lnk(lnk), .frame_point,
    .rd_bank, .rd_addr, .rd_data, .link_spi, .link_i2c);
  ssrp_monitor u_ssrp_monitor(.mclk, .reset, .sel_n(lnk.sel_n),
    .sck(lnk.sck), .host_sdi(lnk.host_sdi), .sdo_oe(lnk.sdo_oe),
    .dev_sda_oe(lnk.dev_sda_oe));
  // ----------------------------------------------------------------
  // clock, timeout, wire capture
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    sck_q <= lnk.sck;
    // sdo is reloaded soon after the last rise of a byte, so take it at rise
    if (lnk.sck === 1'b1 && sck_q === 1'b0)
    begin
      tx_bits <= {lnk.sdi_line, tx_bits[31:1]};
      rx_bits <= {lnk.sdo_line, rx_bits[31:1]};
    end
    if (cycles == 30000)
    begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge mclk);
      if (awready === 1'b1 && !aw_ok)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, AXI_OKAY});
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd_word = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task go(input logic [7:0] c, input logic [7:0] a, input logic [3:0] n,
    input logic [31:0] t0);
    axi_wr(OFS_TXD0, t0);
    axi_wr(OFS_TXD1, 32'h0);
    axi_wr(OFS_CTRL, {1'b1, 11'h000, n, a, c});
  endtask
  task fin;
    int k;
    k = 0;
    do
    begin
      axi_rd(OFS_STAT);
      k++;
    end
    while (rd_word[STAT_DONE_BIT] !== 1'b1 && k < 300);
    chk({30'h0, rd_word[1:0]}, 32'h2);
    axi_rd(OFS_RXD0);
    rx0 = rd_word;
  endtask
  task dchk(input logic [2:0] b, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd_bank <= b;
    rd_addr <= a;
    repeat (2) @(posedge mclk);
    chk({24'h0, rd_data}, {24'h0, e});
  endtask
  task pulse;
    @(posedge mclk);
    frame_point <= 1'b1;
    @(posedge mclk);
    frame_point <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk({30'h0, link_spi, link_i2c}, 32'h0);
    axi_rd(8'h18);
    chk({rd_word[29:0], rd_resp}, {30'h0, AXI_SLVERR});
    dchk(3'h0, 8'h0F, 8'h00);
    $display("test reset done");
  endtask
  task t_imm;
    go(8'h02, 8'h0F, 4'h2, 32'h00005AA5);
    fin();
    chk(rx0[15:0], 32'h0);
    chk(tx_bits, 32'h5AA50F02);
    dchk(3'h0, 8'h0F, 8'hA5);
    dchk(3'h0, 8'h10, 8'h00);
    pulse();
    dchk(3'h0, 8'h10, 8'h5A);
    chk({30'h0, link_spi, link_i2c}, 32'h2);
    $display("test write done");
  endtask
  task t_old;
    go(8'h02, 8'h0F, 4'h2, 32'h0000C33C);
    fin();
    chk(rx0[15:0], 32'h5AA5);
    chk(rx_bits[31:16], 32'h5AA5);
    pulse();
    dchk(3'h0, 8'h0F, 8'h3C);
    dchk(3'h0, 8'h10, 8'hC3);
    $display("test old value done");
  endtask
  task t_read;
    go(8'h82, 8'h0F, 4'h3, 32'h00FFFFFF);
    fin();
    chk(rx0[23:0], 32'h0000C33C);
    pulse();
    dchk(3'h0, 8'h0F, 8'h3C);
    dchk(3'h0, 8'h11, 8'h00);
    $display("test read done");
  endtask
  task t_banks;
    logic [7:0] bad [4];
    // 0Ah and 0Eh would alias onto banks 0 and 4 if range went unchecked
    bad = '{8'h01, 8'h07, 8'h0A, 8'h0E};
    for (int b = 0; b < 5; b++)
    begin
      go(8'h02 + 8'(b), 8'h40, 4'h1, 32'h60 + b);
      fin();
      go(8'h82 + 8'(b), 8'h40, 4'h1, 32'h0);
      fin();
      chk(rx0[7:0], 32'h60 + b);
    end
    for (int i = 0; i < 4; i++)
    begin
      go(bad[i], 8'h40, 4'h1, 32'hEE);
      fin();
    end
    pulse();
    for (int b = 0; b < 5; b++)
      dchk(3'(b), 8'h40, 8'h60 + 8'(b));
    $display("test banks done");
  endtask
  task t_window;
    window_ok <= 1'b0;
    go(8'h02, 8'h50, 4'h1, 32'h77);
    repeat (30) @(posedge mclk);
    axi_rd(OFS_STAT);
    chk({rd_word[0], lnk.sel_n}, 32'h3);
    window_ok <= 1'b1;
    fin();
    pulse();
    dchk(3'h0, 8'h50, 8'h77);
    $display("test window done");
  endtask
  task t_regs;
    go(8'h83, 8'h3C, 4'hF, 32'h0);
    fin();
    chk(rx0, 32'h0);
    axi_rd(OFS_RXD1);
    chk(rd_word, 32'h00000061);
    axi_rd(OFS_CTRL);
    chk(rd_word, 32'h00083C83);
    $display("test long read done");
  endtask
  task t_again;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({30'h0, link_spi, link_i2c}, 32'h0);
    dchk(3'h0, 8'h0F, 8'h00);
    $display("test second reset done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset, window_ok} = 2'h3;
    {frame_point, rd_bank, rd_addr, awaddr, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, sck_q} = '0;
    {wdata, wstrb, tx_bits, rx_bits} = '0;
    {bad_count, checks_done, cycles} = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    t_imm();
    t_old();
    t_read();
    t_banks();
    t_window();
    t_regs();
    t_again();
    wrap_up();
  end
endmodule // tb_top
